// File: btob_defs.svh
// Purpose: Constants for the bit-test, bit-invert and overflow-branch executor
// Assumes: 16-bit instruction words, 12-bit data addresses, 21-bit byte program counter
// Notes:   Wishbone register offsets are byte addresses of aligned 32-bit words
`ifndef BTOB_DEFS_SVH
`define BTOB_DEFS_SVH

// Opcode fields
`define BTOB_OP_SKIP_SET    4'hA
`define BTOB_OP_SKIP_CLR    4'hB
`define BTOB_OP_INVERT      4'h7
`define BTOB_OP_BRANCH_OVF  8'hE4

// Instruction field positions
`define BTOB_BIT_HI         11
`define BTOB_BIT_LO         9
`define BTOB_ACC_BIT        8

// Access bank split: low file addresses map to bank 0, high ones to the top bank
`define BTOB_ACC_SPLIT      8'h80
`define BTOB_ACC_HI_BANK    4'hF
`define BTOB_ACC_LO_BANK    4'h0

// Sequential step of the program counter in bytes
`define BTOB_PC_STEP        21'h000002

// Last quarter phase of an instruction cycle, after which the counter wraps to 0
`define BTOB_QPHASES        2'h3

// Register offsets
`define BTOB_REG_BANK       4'h0
`define BTOB_REG_STATUS     4'h4
`define BTOB_REG_LAST       4'h8

// Field positions and reset values
`define BTOB_ST_OVF         0
`define BTOB_ST_BUSY        1
`define BTOB_BANK_RST       4'h0
`define BTOB_OVF_RST        1'h0

`endif

// File: btob_pkg.sv
// Purpose: Types for the bit-test, bit-invert and overflow-branch executor
// Assumes: Constants live in btob_defs.svh
// Notes:   None
package btob_pkg;

  typedef enum logic [1:0] {
    BTOB_K_NONE,
    BTOB_K_SKIP,
    BTOB_K_INVERT,
    BTOB_K_BRANCH
  } btob_kind_e;

  typedef enum logic [1:0] {
    BTOB_S_IDLE,
    BTOB_S_EXEC,
    BTOB_S_NOP
  } btob_state_e;

  typedef logic [20:0] btob_pc_t;
  typedef logic [11:0] btob_daddr_t;

endpackage : btob_pkg

// File: btob_qphase.sv
// Purpose: Quarter-phase counter dividing mclk into Q1..Q4 of an instruction cycle
// Assumes: One instruction cycle is four mclk cycles
// Notes:   Phase 0 is Q1
`timescale 1ns/1ps
`default_nettype none
`include "btob_defs.svh"

module btob_qphase (
  input  wire logic       mclk,   // System clock
  input  wire logic       nrst,   // Async reset, active low
  output var  logic [1:0] qph     // Current quarter phase
);

  logic [1:0] next_qph;

  always_comb begin
    next_qph = (qph == `BTOB_QPHASES) ? 2'h0 : qph + 2'h1;
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      qph <= 2'h0;
    end else begin
      qph <= next_qph;
    end
  end

endmodule : btob_qphase
`default_nettype wire

// File: btob_core.sv
// Purpose: Executes bit-test-skip, bit-invert and overflow-branch instructions
// Assumes: Data memory read is combinational; instruction offered at Q1 with its PC
// Notes:   Registers reached over classic Wishbone; status flag ovf is written only over Wishbone, never by the executor
//
// Added by the designer: the placing of the registers and the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "btob_defs.svh"

module btob_core (
  input  wire logic                  mclk,           // System clock, 40 MHz
  input  wire logic                  nrst,           // Async reset, active low
  input  wire logic                  instr_valid,    // Instruction offered in Q1
  input  wire logic [15:0]           instr_word,     // Instruction word
  input  wire btob_pkg::btob_pc_t    instr_pc,       // Address of the instruction
  input  wire logic                  next_two_word,  // Prefetched word starts a two-word instruction
  output var  logic                  instr_ready,    // Executor can take an instruction at Q1
  output var  logic                  instr_done,     // Last Q4 of the instruction
  output var  logic                  nop_cycle,      // Flush cycle in progress
  output var  logic                  flush_prefetch, // Discard the prefetched word
  output var  btob_pkg::btob_daddr_t dm_addr,        // Data memory address
  output var  logic                  dm_re,          // Data memory read
  input  wire logic [7:0]            dm_rdata,       // Data memory read data
  output var  logic [7:0]            dm_wdata,       // Data memory write data
  output var  logic                  dm_we,          // Data memory write in Q4
  output var  logic                  pc_load,        // Load program counter in Q4
  output var  btob_pkg::btob_pc_t    pc_value,       // New program counter
  input  wire logic                  wb_cyc_i,       // Wishbone cycle
  input  wire logic                  wb_stb_i,       // Wishbone strobe
  input  wire logic                  wb_we_i,        // Wishbone write
  input  wire logic [3:0]            wb_adr_i,       // Wishbone byte address
  input  wire logic [3:0]            wb_sel_i,       // Wishbone byte selects
  input  wire logic [31:0]           wb_dat_i,       // Wishbone write data
  output var  logic [31:0]           wb_dat_o,       // Wishbone read data
  output var  logic                  wb_ack_o        // Wishbone acknowledge
);
  import btob_pkg::*;

  function automatic btob_kind_e classify(input logic [15:0] w);
    if (w[15:12] == `BTOB_OP_SKIP_SET || w[15:12] == `BTOB_OP_SKIP_CLR) begin
      return BTOB_K_SKIP;
    end else if (w[15:12] == `BTOB_OP_INVERT) begin
      return BTOB_K_INVERT;
    end else if (w[15:8] == `BTOB_OP_BRANCH_OVF) begin
      return BTOB_K_BRANCH;
    end
    return BTOB_K_NONE;
  endfunction : classify

  logic [1:0] qph;

  btob_qphase u_qph (
    .mclk (mclk),
    .nrst (nrst),
    .qph  (qph)
  );

  // Register file
  logic [3:0]  bank_select_reg;
  logic        ovf;
  logic [1:0]  last_cycles;
  logic [3:0]  next_bank;
  logic        next_ovf;
  logic [31:0] next_wb_dat;
  logic        next_wb_ack;
  logic        wb_hit;

  // Executor state
  btob_state_e state;
  btob_kind_e  kind;
  logic [15:0] iw;
  btob_pc_t    ipc;
  logic        two_word;
  logic [7:0]  rdata;
  logic        nop_left;
  logic [1:0]  cyc_cnt;

  btob_state_e next_state;
  btob_kind_e  next_kind;
  logic [15:0] next_iw;
  btob_pc_t    next_ipc;
  logic        next_two_word_l;
  logic [7:0]  next_rdata;
  logic        next_nop_left;
  logic [1:0]  next_cyc_cnt;
  logic [1:0]  next_last;
  logic        next_ready;
  logic        next_done;
  logic        next_nop_cycle;
  logic        next_flush;
  btob_daddr_t next_dm_addr;
  logic        next_dm_re;
  logic [7:0]  next_dm_wdata;
  logic        next_dm_we;
  logic        next_pc_load;
  btob_pc_t    next_pc_value;

  logic        take;
  logic        bit_val;
  logic        do_skip;
  logic        do_jump;
  logic [7:0]  fsel;
  logic [2:0]  bsel;

  assign wb_hit = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign take   = (state == BTOB_S_IDLE) && (qph == 2'h0) && instr_valid;
  assign fsel   = take ? instr_word[7:0] : iw[7:0];
  assign bsel   = iw[`BTOB_BIT_HI:`BTOB_BIT_LO];
  assign bit_val = dm_rdata[bsel];
  // Bit 12 separates skip-if-clear from skip-if-set
  assign do_skip = (kind == BTOB_K_SKIP) && (bit_val == ~iw[12]);
  assign do_jump = (kind == BTOB_K_BRANCH) && ovf;

  always_comb begin
    next_bank   = bank_select_reg;
    next_ovf    = ovf;
    next_wb_dat = 32'h00000000;
    next_wb_ack = wb_hit;
    if (wb_hit && wb_we_i && wb_sel_i[0]) begin
      unique case (wb_adr_i)
        `BTOB_REG_BANK:   next_bank = wb_dat_i[3:0];
        `BTOB_REG_STATUS: next_ovf  = wb_dat_i[`BTOB_ST_OVF];
        default:          next_bank = bank_select_reg;
      endcase
    end
    if (wb_hit && !wb_we_i) begin
      unique case (wb_adr_i)
        `BTOB_REG_BANK:   next_wb_dat = {28'h0000000, bank_select_reg};
        `BTOB_REG_STATUS: next_wb_dat = {30'h00000000, state != BTOB_S_IDLE, ovf};
        `BTOB_REG_LAST:   next_wb_dat = {30'h00000000, last_cycles};
        default:          next_wb_dat = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      bank_select_reg <= `BTOB_BANK_RST;
      ovf             <= `BTOB_OVF_RST;
      wb_dat_o        <= 32'h00000000;
      wb_ack_o        <= 1'b0;
    end else begin
      bank_select_reg <= next_bank;
      ovf             <= next_ovf;
      wb_dat_o        <= next_wb_dat;
      wb_ack_o        <= next_wb_ack;
    end
  end

  always_comb begin
    next_state      = state;
    next_kind       = kind;
    next_iw         = iw;
    next_ipc        = ipc;
    next_two_word_l = two_word;
    next_rdata      = rdata;
    next_nop_left   = nop_left;
    next_cyc_cnt    = cyc_cnt;
    next_last       = last_cycles;
    next_dm_addr    = dm_addr;
    next_dm_re      = dm_re;
    next_dm_wdata   = dm_wdata;
    next_dm_we      = 1'b0;
    next_pc_load    = 1'b0;
    next_pc_value   = pc_value;
    next_done       = 1'b0;
    next_flush      = flush_prefetch;
    next_nop_cycle  = nop_cycle;
    unique case (state)
      BTOB_S_IDLE: begin
        if (take) begin
          next_state      = BTOB_S_EXEC;
          next_kind       = classify(instr_word);
          next_iw         = instr_word;
          next_ipc        = instr_pc;
          next_two_word_l = next_two_word;
          next_cyc_cnt    = 2'h1;
          next_dm_re      = (classify(instr_word) == BTOB_K_SKIP) || (classify(instr_word) == BTOB_K_INVERT);
          if (instr_word[`BTOB_ACC_BIT]) begin
            next_dm_addr = {bank_select_reg, fsel};
          end else if (fsel < `BTOB_ACC_SPLIT) begin
            next_dm_addr = {`BTOB_ACC_LO_BANK, fsel};
          end else begin
            next_dm_addr = {`BTOB_ACC_HI_BANK, fsel};
          end
        end
      end
      BTOB_S_EXEC: begin
        if (qph == 2'h1) begin
          next_rdata = dm_rdata;
        end else if (qph == 2'h2) begin
          next_dm_re = 1'b0;
          if (kind == BTOB_K_INVERT) begin
            next_dm_wdata = rdata ^ (8'h01 << bsel);
            next_dm_we    = 1'b1;
          end
          if (do_jump) begin
            next_pc_load  = 1'b1;
            next_pc_value = ipc + `BTOB_PC_STEP + {{12{iw[7]}}, iw[7:0], 1'b0};
          end
          next_flush    = do_skip || do_jump;
          next_nop_left = do_skip && two_word;
        end else if (qph == 2'h3) begin
          if (flush_prefetch) begin
            next_state     = BTOB_S_NOP;
            next_nop_cycle = 1'b1;
            next_flush     = 1'b0;
          end else begin
            next_state = BTOB_S_IDLE;
            next_done  = 1'b0;
            next_last  = cyc_cnt;
          end
        end
        if (qph == 2'h2 && !do_skip && !do_jump) begin
          next_done = 1'b1;
        end
      end
      BTOB_S_NOP: begin
        if (qph == 2'h2 && !nop_left) begin
          next_done = 1'b1;
        end
        if (qph == 2'h3) begin
          next_cyc_cnt = cyc_cnt + 2'h1;
          if (nop_left) begin
            next_nop_left = 1'b0;
          end else begin
            next_state     = BTOB_S_IDLE;
            next_nop_cycle = 1'b0;
            next_last      = cyc_cnt + 2'h1;
          end
        end
      end
    endcase
    next_ready = (next_state == BTOB_S_IDLE);
  end

  // Status flags are never driven from here, ovf is only read
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      state          <= BTOB_S_IDLE;
      kind           <= BTOB_K_NONE;
      iw             <= 16'h0000;
      ipc            <= 21'h000000;
      two_word       <= 1'b0;
      rdata          <= 8'h00;
      nop_left       <= 1'b0;
      cyc_cnt        <= 2'h0;
      last_cycles    <= 2'h0;
      instr_ready    <= 1'b1;
      instr_done     <= 1'b0;
      nop_cycle      <= 1'b0;
      flush_prefetch <= 1'b0;
      dm_addr        <= 12'h000;
      dm_re          <= 1'b0;
      dm_wdata       <= 8'h00;
      dm_we          <= 1'b0;
      pc_load        <= 1'b0;
      pc_value       <= 21'h000000;
    end else begin
      state          <= next_state;
      kind           <= next_kind;
      iw             <= next_iw;
      ipc            <= next_ipc;
      two_word       <= next_two_word_l;
      rdata          <= next_rdata;
      nop_left       <= next_nop_left;
      cyc_cnt        <= next_cyc_cnt;
      last_cycles    <= next_last;
      instr_ready    <= next_ready;
      instr_done     <= next_done;
      nop_cycle      <= next_nop_cycle;
      flush_prefetch <= next_flush;
      dm_addr        <= next_dm_addr;
      dm_re          <= next_dm_re;
      dm_wdata       <= next_dm_wdata;
      dm_we          <= next_dm_we;
      pc_load        <= next_pc_load;
      pc_value       <= next_pc_value;
    end
  end

endmodule : btob_core
`default_nettype wire

// File: btob_core_chk.sv
// Purpose: Port-level timing and value checks for btob_core
// Assumes: Takes happen on every fourth edge after reset release
// Notes:   The quarter phase is rebuilt here from reset
`timescale 1ns/1ps
`default_nettype none
`include "btob_defs.svh"
module btob_core_chk (
  input wire logic               mclk,           // Clock
  input wire logic               nrst,           // Reset, active low
  input wire logic               instr_valid,    // Offer
  input wire logic [15:0]        instr_word,     // Word
  input wire btob_pkg::btob_pc_t instr_pc,       // Address
  input wire logic               next_two_word,  // Two-word follower
  input wire logic               instr_ready,    // Idle
  input wire logic               instr_done,     // Done
  input wire logic               nop_cycle,      // Flush cycle
  input wire logic               flush_prefetch, // Discard
  input wire btob_pkg::btob_daddr_t dm_addr,     // Data address
  input wire logic [7:0]         dm_rdata,       // Read data
  input wire logic [7:0]         dm_wdata,       // Write data
  input wire logic               dm_we,          // Write
  input wire logic               pc_load,        // PC load
  input wire btob_pkg::btob_pc_t pc_value,       // New PC
  input wire logic               wb_cyc_i,       // Cycle
  input wire logic               wb_stb_i,       // Strobe
  input wire logic               wb_ack_o        // Ack
);
  import btob_pkg::*;
  logic [1:0] ph;
  logic [1:0] next_ph;
  logic       take;
  logic       skp;
  always_comb next_ph = ph + 2'h1;
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) ph <= 2'h0;
    else ph <= next_ph;
  end
  assign take = (ph == 2'h0) && instr_ready && instr_valid;
  assign skp = instr_word[15:13] == 3'h5;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);
  AST_INV_ONE: assert property (take && instr_word[15:12] == `BTOB_OP_INVERT |-> ##3 instr_done && dm_we
    && ((dm_wdata ^ $past(dm_rdata)) == (8'h01 << $past(instr_word[11:9], 3)))) else $error("invert wrong");
  AST_BANK_ACC: assert property (take && !instr_word[8] && (skp || instr_word[15:12] == `BTOB_OP_INVERT)
    |=> dm_addr == {$past(instr_word[7]) ? `BTOB_ACC_HI_BANK : `BTOB_ACC_LO_BANK, $past(instr_word[7:0])})
    else $error("access bank address wrong");
  AST_SKIP_BIT: assert property (take && instr_word[15:12] == `BTOB_OP_SKIP_SET |-> ##3
    flush_prefetch == |(($past(dm_rdata) >> $past(instr_word[11:9], 3)) & 8'h01)) else $error("skip test wrong");
  AST_SKIP_SHORT: assert property (take && skp && !next_two_word ##3 flush_prefetch |-> ##4 instr_done)
    else $error("skip length wrong");
  AST_SKIP_LONG: assert property (take && skp && next_two_word ##3 flush_prefetch |-> ##8 instr_done)
    else $error("two-word skip length wrong");
  AST_NO_SKIP: assert property (take && skp ##3 !flush_prefetch |-> instr_done) else $error("no-skip length");
  AST_BR_PC: assert property (take && instr_word[15:8] == `BTOB_OP_BRANCH_OVF |-> ##3 (!pc_load || pc_value ==
    $past(instr_pc, 3) + `BTOB_PC_STEP + {{12{$past(instr_word[7], 3)}}, $past(instr_word[7:0], 3), 1'b0}))
    else $error("branch target wrong");
  AST_BR_TAKEN: assert property (pc_load |-> flush_prefetch ##1 nop_cycle[*4] ##0 instr_done)
    else $error("taken branch timing wrong");
  AST_PC_ONLY: assert property (pc_load |-> $past(instr_word[15:8], 3) == `BTOB_OP_BRANCH_OVF)
    else $error("pc load without branch");
  AST_WB_ACK: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("ack timing wrong");
endmodule : btob_core_chk
bind btob_core btob_core_chk u_chk (.mclk, .nrst, .instr_valid, .instr_word, .instr_pc, .next_two_word,
  .instr_ready, .instr_done, .nop_cycle, .flush_prefetch, .dm_addr, .dm_rdata, .dm_wdata, .dm_we,
  .pc_load, .pc_value, .wb_cyc_i, .wb_stb_i, .wb_ack_o);
`default_nettype wire

// File: bit_test_toggle_ovf_branch_tb.sv
// Purpose: Directed bench for btob_core
// Assumes: Memory read data held constant for each instruction
// Notes:   Cycle counts are edges from take to done
`timescale 1ns/1ps
`default_nettype none
`include "btob_defs.svh"
module bit_test_toggle_ovf_branch_tb;
  import btob_pkg::*;
  logic        mclk = 0, nrst = 0, instr_valid = 0, next_two_word = 0;
  logic        wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
  logic [3:0]  wb_adr_i = 0, wb_sel_i = 4'hF;
  logic [31:0] wb_dat_i = 0, wb_dat_o, q;
  logic [15:0] instr_word = 0;
  logic [7:0]  dm_rdata = 0, dm_wdata, wd;
  btob_pc_t    instr_pc = 0, pc_value, pv;
  btob_daddr_t dm_addr, ad;
  logic        instr_ready, instr_done, nop_cycle, flush_prefetch, dm_re, dm_we, pc_load, wb_ack_o;
  logic        rd_seen;
  int          mismatches = 0, n_compared = 0, tick = 0, cnt = 0, n, pl, fl;
  btob_core u_dut (.mclk(mclk), .nrst(nrst), .instr_valid(instr_valid), .instr_word(instr_word),
    .instr_pc(instr_pc), .next_two_word(next_two_word), .instr_ready(instr_ready), .instr_done(instr_done),
    .nop_cycle(nop_cycle), .flush_prefetch(flush_prefetch), .dm_addr(dm_addr), .dm_re(dm_re),
    .dm_rdata(dm_rdata), .dm_wdata(dm_wdata), .dm_we(dm_we), .pc_load(pc_load), .pc_value(pc_value),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o));
  initial forever #12.5 mclk = ~mclk;
  always @(posedge mclk) begin
    tick++;
    // Non-blocking so the tasks read a race-free phase count
    if (nrst) cnt <= cnt + 1;
    if (tick == 5000) begin
      mismatches++;
      end_of_test();
    end
  end
  task end_of_test;
    $display("Compared %0d, mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : end_of_test
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      mismatches++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do @(posedge mclk); while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : wb
  task run(input logic [15:0] w, input logic [7:0] rd, input logic two, input btob_pc_t pc);
    @(posedge mclk);
    while (cnt[1:0] != 2'h3 || instr_ready !== 1'b1) @(posedge mclk);
    instr_word    <= w;
    dm_rdata      <= rd;
    next_two_word <= two;
    instr_pc      <= pc;
    instr_valid   <= 1'b1;
    @(posedge mclk);
    instr_valid <= 1'b0;
    n = 0;
    pl = 0;
    fl = 0;
    do begin
      @(posedge mclk);
      n++;
      if (n == 1) ad = dm_addr;
      if (n == 1) rd_seen = dm_re;
      if (dm_we === 1'b1) wd = dm_wdata;
      if (pc_load === 1'b1) pl++;
      if (pc_load === 1'b1) pv = pc_value;
      if (flush_prefetch === 1'b1) fl++;
    end while (instr_done !== 1'b1 && n < 20);
  endtask : run
  task t_regs;
    wb(0, `BTOB_REG_BANK, 0);
    chk("bank reset", 0, q);
    wb(1, 4'hC, 32'h5);
    wb(0, 4'hC, 0);
    chk("unmapped", 0, q);
    wb(1, `BTOB_REG_BANK, 32'h5);
    wb(0, `BTOB_REG_BANK, 0);
    chk("bank", 32'h5, q);
    wb_sel_i <= 4'h0;
    wb(1, `BTOB_REG_BANK, 32'h9);
    wb_sel_i <= 4'hF;
    wb(0, `BTOB_REG_BANK, 0);
    chk("sel ignored", 32'h5, q);
    run(16'h7333, 8'h00, 0, 0);
    chk("bsr addr", 12'h533, ad);
    run(16'h7233, 8'h00, 0, 0);
    chk("low access", 12'h033, ad);
    wb(1, `BTOB_REG_BANK, 0);
  endtask : t_regs
  task t_invert;
    for (int b = 0; b < 8; b++) begin
      run({4'h7, 3'(b), 1'b0, 8'h85}, 8'h75, 0, 0);
      chk("invert cycles", 3, n);
      chk("read strobe", 1, rd_seen);
      chk("invert data", 8'h75 ^ (8'h01 << b), wd);
      chk("high access", 12'hF85, ad);
    end
  endtask : t_invert
  task sk(input logic [15:0] w, input logic [7:0] rd, input logic two, input int en);
    run(w, rd, two, 0);
    chk("skip cycles", en, n);
    chk("flush", en > 3, fl);
  endtask : sk
  task t_skip;
    sk(16'hA212, 8'h02, 0, 7);
    sk(16'hA212, 8'hFD, 0, 3);
    sk(16'hAE12, 8'h80, 1, 11);
    sk(16'hAE12, 8'h7F, 1, 3);
    sk(16'hB012, 8'hFE, 0, 7);
    sk(16'hB012, 8'h01, 0, 3);
  endtask : t_skip
  task t_branch;
    wb(1, `BTOB_REG_STATUS, 0);
    run(16'hE405, 0, 0, 21'h000100);
    chk("untaken cycles", 3, n);
    chk("untaken load", 0, pl);
    chk("branch no read", 0, rd_seen);
    wb(1, `BTOB_REG_STATUS, 1);
    run(16'hE480, 0, 0, 21'h000100);
    chk("taken cycles", 7, n);
    chk("target back", 21'h000002, pv);
    run(16'hE47F, 0, 0, 21'h001000);
    chk("target fwd", 21'h001100, pv);
    chk("taken flush", 1, fl);
    wb(0, `BTOB_REG_LAST, 0);
    chk("last cycles", 2, q);
    wb(0, `BTOB_REG_STATUS, 0);
    chk("flag kept", 1, q[0]);
  endtask : t_branch
  initial begin
    repeat (20) @(posedge mclk);
    nrst <= 1'b1;
    t_regs();
    t_invert();
    t_skip();
    t_branch();
    end_of_test();
  end
endmodule : bit_test_toggle_ovf_branch_tb
`default_nettype wire
